// ---- verilog/acs_defines.vh ----
// constants for the calibration scaler: register indexes, command codes,
// fixed-point figures and calibration timing counts
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// register indexes (one byte each, low byte first)
`define ACS_REG_OFS0      3'h0
`define ACS_REG_OFS1      3'h1
`define ACS_REG_OFS2      3'h2
`define ACS_REG_GAIN0     3'h3
`define ACS_REG_GAIN1     3'h4
`define ACS_REG_GAIN2     3'h5

// reset values of the correction words
`define ACS_OFS_RESET     24'h000000
`define ACS_GAIN_RESET    24'h400000

// gain normalisation: 400000h is 1.0, so the product shifts by 22
`define ACS_GAIN_SHIFT    22

// saturation limits of the 16-bit two's complement output code
`define ACS_CODE_MAX      16'h7FFF
`define ACS_CODE_MIN      16'h8000

// calibration command codes on cmd_code
`define ACS_CMD_SYS_OFS   2'h1
`define ACS_CMD_INT_OFS   2'h2
`define ACS_CMD_SYS_GAIN  2'h3

// calibration timing
`define ACS_CAL_CONV      16
`define ACS_CAL_SYS_CLKS  50
`define ACS_CAL_MOD_CLKS  32

`endif

// ---- verilog/acs_scaler.v ----
// calibration scaler: offset subtract, gain multiply, 16-bit clip, plus the
// calibration command sequencer that refreshes the correction words.
// assumes filter results, commands and modulator ticks come from logic on
// clk_sys; the serial front end that decodes host bytes lives elsewhere.
//
// Overview of operation
// - subtract upper sixteen offset bits, then multiply by gain over 400000h
// - clip the scaled result to sixteen bits instead of wrapping
// - correction words load from host writes or from calibration results
// - offset word is 24-bit two's complement in three byte registers
// - upper offset bits span full scale; low byte is sub-lsb from calibration
// - zero offset corrects nothing; 000100h gives FFFFh at zero input
// - gain word is unsigned, 400000h is one and 800000h is two
// - accept system gain, system offset and internal offset calibration
// - calibration end drops the done flag; first later result is valid
// - stop or power-down during calibration waits until calibration ends
// - system offset: host applies zero input, device updates offset word
// - internal offset: disconnect inputs, apply internal zero, update offset
// - offset calibration abandons current conversion and starts at once
// - gain calibration: full-scale input, abandon conversion, update gain
// - each calibration averages sixteen consecutive conversions
// - calibration takes 50 system, 32 modulator and 16 data periods
// - host link is a full-duplex serial port plus the done flag
`timescale 1ns/100ps
`include "acs_defines.vh"

module acs_scaler #(
  parameter CAL_CONV     = `ACS_CAL_CONV,
  parameter CAL_SYS_CLKS = `ACS_CAL_SYS_CLKS,
  parameter CAL_MOD_CLKS = `ACS_CAL_MOD_CLKS
) (
  input  wire        clk_sys,
  input  wire        rst,
  // raw filter output, one pulse per conversion
  input  wire [15:0] filt_data,
  input  wire        filt_valid,
  // one pulse per modulator clock period
  input  wire        mod_tick,
  // decoded command strobe from the serial front end
  input  wire        cmd_valid,
  input  wire [1:0]  cmd_code,
  input  wire        power_down_req,
  input  wire        start_pin_low,
  // byte-wide register access from the serial front end
  input  wire        reg_wr,
  input  wire [2:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // delivered code and its done flag (active low as the pin, low for one clock only)
  output reg  [15:0] out_code,
  output reg         conversion_done_flag_n,
  output reg         out_valid,
  // analog front end control during calibration
  output reg         input_disconnect,
  output reg         internal_zero_apply,
  output reg         filter_restart,
  output reg         cal_busy,
  output reg         power_down
);

  localparam ST_IDLE  = 4'b0001;
  localparam ST_SETUP = 4'b0010;
  localparam ST_ACCUM = 4'b0100;
  localparam ST_DONE  = 4'b1000;

  reg  [23:0] offset_correction_value_reg;
  reg  [23:0] gain_correction_value_reg;
  reg  [3:0]  state_reg;
  reg  [1:0]  cal_kind_reg;
  reg  [5:0]  sys_cnt_reg;
  reg  [5:0]  mod_cnt_reg;
  reg  [4:0]  conv_cnt_reg;
  reg  [19:0] acc_reg;
  reg         pd_pending_reg;
  reg  [47:0] prod;
  reg  [16:0] diff;
  reg  [25:0] scaled;
  reg  [15:0] clipped;
  wire        sys_ofs_cmd;
  wire        int_ofs_cmd;
  wire        sys_gain_cmd;
  wire        cal_cmd;
  wire [19:0] sample_ext;
  wire [15:0] avg;
  wire [23:0] avg_fine;
  wire [23:0] new_gain;
  wire [47:0] gain_quot;

  assign sys_ofs_cmd  = cmd_valid && (cmd_code == `ACS_CMD_SYS_OFS);
  assign int_ofs_cmd  = cmd_valid && (cmd_code == `ACS_CMD_INT_OFS);
  assign sys_gain_cmd = cmd_valid && (cmd_code == `ACS_CMD_SYS_GAIN);
  assign cal_cmd = sys_ofs_cmd || int_ofs_cmd || sys_gain_cmd;

  // difference kept at 17 bits so a full-scale span cannot wrap
  // offset subtract first
  // zero offset word leaves the code alone
  always @* begin
    diff = {filt_data[15], filt_data} -
           {offset_correction_value_reg[23],
            offset_correction_value_reg[23:8]};
    // unsigned gain word, 400000h is unity
    prod = $signed({{31{diff[16]}}, diff}) *
           $signed({24'h000000, gain_correction_value_reg});
    scaled = prod[`ACS_GAIN_SHIFT+25:`ACS_GAIN_SHIFT];
    if (!scaled[25] && (scaled[24:15] != 10'h000))
      clipped = `ACS_CODE_MAX;
    else if (scaled[25] && (scaled[24:15] != 10'h3FF))
      clipped = `ACS_CODE_MIN;
    else
      clipped = scaled[15:0];
  end

  // sum of sixteen raw results; divide by shifting
  assign sample_ext = {{4{filt_data[15]}}, filt_data};
  assign avg        = acc_reg[19:4];
  // averaged fraction keeps sub-lsb detail for the low offset byte
  assign avg_fine   = {acc_reg[19:0], 4'h0};
  // new gain maps the averaged full-scale reading onto 7FFFh
  assign gain_quot  = ({24'h000000, gain_correction_value_reg} *
                       48'h007FFF) / {32'h00000000, avg};
  assign new_gain   = (avg[15] || avg == 16'h0000) ? gain_correction_value_reg
                      : gain_quot[23:0];

  always @(posedge clk_sys) begin
    if (rst) begin
      state_reg                   <= ST_IDLE;
      cal_kind_reg                <= 2'h0;
      sys_cnt_reg                 <= 6'h00;
      mod_cnt_reg                 <= 6'h00;
      conv_cnt_reg                <= 5'h00;
      acc_reg                     <= 20'h00000;
      pd_pending_reg              <= 1'b0;
      offset_correction_value_reg <= `ACS_OFS_RESET;
      gain_correction_value_reg   <= `ACS_GAIN_RESET;
      out_code                    <= 16'h0000;
      out_valid                   <= 1'b0;
      conversion_done_flag_n      <= 1'b1;
      input_disconnect            <= 1'b0;
      internal_zero_apply         <= 1'b0;
      filter_restart              <= 1'b0;
      cal_busy                    <= 1'b0;
      power_down                  <= 1'b0;
      reg_rdata                   <= 8'h00;
    end else begin
      out_valid      <= 1'b0;
      filter_restart <= 1'b0;
      // done flag rises again after the low-going indication
      if (filt_valid && state_reg == ST_IDLE)
        conversion_done_flag_n <= 1'b0;
      else if (!conversion_done_flag_n)
        conversion_done_flag_n <= 1'b1;

      case (reg_addr)
        `ACS_REG_OFS0:  reg_rdata <= offset_correction_value_reg[7:0];
        `ACS_REG_OFS1:  reg_rdata <= offset_correction_value_reg[15:8];
        `ACS_REG_OFS2:  reg_rdata <= offset_correction_value_reg[23:16];
        `ACS_REG_GAIN0: reg_rdata <= gain_correction_value_reg[7:0];
        `ACS_REG_GAIN1: reg_rdata <= gain_correction_value_reg[15:8];
        `ACS_REG_GAIN2: reg_rdata <= gain_correction_value_reg[23:16];
        default:        reg_rdata <= 8'h00;
      endcase

      case (state_reg)
        ST_IDLE: begin
          if (cal_cmd) begin
            state_reg        <= ST_SETUP;
            cal_kind_reg     <= cmd_code;
            cal_busy         <= 1'b1;
            filter_restart   <= 1'b1;
            sys_cnt_reg      <= 6'h00;
            mod_cnt_reg      <= 6'h00;
            conv_cnt_reg     <= 5'h00;
            acc_reg          <= 20'h00000;
            pd_pending_reg   <= 1'b0;
            power_down       <= 1'b0;
            input_disconnect    <= int_ofs_cmd;
            internal_zero_apply <= int_ofs_cmd;
          end else begin
            power_down <= power_down_req || start_pin_low;
            if (reg_wr) begin
              case (reg_addr)
                `ACS_REG_OFS0:
                  offset_correction_value_reg[7:0]   <= reg_wdata;
                `ACS_REG_OFS1:
                  offset_correction_value_reg[15:8]  <= reg_wdata;
                `ACS_REG_OFS2:
                  offset_correction_value_reg[23:16] <= reg_wdata;
                `ACS_REG_GAIN0:
                  gain_correction_value_reg[7:0]     <= reg_wdata;
                `ACS_REG_GAIN1:
                  gain_correction_value_reg[15:8]    <= reg_wdata;
                `ACS_REG_GAIN2:
                  gain_correction_value_reg[23:16]   <= reg_wdata;
                default: ;
              endcase
            end
            if (filt_valid) begin
              out_code  <= clipped;
              out_valid <= 1'b1;
            end
          end
        end
        ST_SETUP: begin
          // fixed settling: system and modulator periods
          if (sys_cnt_reg != CAL_SYS_CLKS[5:0])
            sys_cnt_reg <= sys_cnt_reg + 6'h01;
          if (mod_tick && mod_cnt_reg != CAL_MOD_CLKS[5:0])
            mod_cnt_reg <= mod_cnt_reg + 6'h01;
          if (sys_cnt_reg == CAL_SYS_CLKS[5:0] &&
              mod_cnt_reg == CAL_MOD_CLKS[5:0])
            state_reg <= ST_ACCUM;
        end
        ST_ACCUM: begin
          if (filt_valid) begin
            acc_reg      <= acc_reg + sample_ext;
            conv_cnt_reg <= conv_cnt_reg + 5'h01;
            if (conv_cnt_reg == CAL_CONV[4:0] - 5'h01)
              state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          // gain word after gain calibration, else offset word from averaged zero input
          if (cal_kind_reg == `ACS_CMD_SYS_GAIN)
            gain_correction_value_reg <= new_gain;
          else
            offset_correction_value_reg <= avg_fine;
          state_reg           <= ST_IDLE;
          cal_busy            <= 1'b0;
          input_disconnect    <= 1'b0;
          internal_zero_apply <= 1'b0;
          conversion_done_flag_n <= 1'b0;
          power_down <= pd_pending_reg || power_down_req || start_pin_low;
        end
        default: state_reg <= ST_IDLE;
      endcase

      if (state_reg != ST_IDLE && state_reg != ST_DONE &&
          (power_down_req || start_pin_low))
        pd_pending_reg <= 1'b1;
    end
  end

endmodule

// ---- sim/acs_scaler_monitor.sv ----
// checker for acs_scaler: result handshake and calibration sequencing
// assumes a bind onto acs_scaler, seeing its ports only
`timescale 1ns/100ps
module acs_scaler_chk (
  input wire       clk_sys,
  input wire       rst,
  input wire       filt_valid,
  input wire       cmd_valid,
  input wire [1:0] cmd_code,
  input wire       out_valid,
  input wire       conversion_done_flag_n,
  input wire       cal_busy,
  input wire       filter_restart,
  input wire       input_disconnect,
  input wire       internal_zero_apply,
  input wire       power_down
);
  reg  [15:0] busy_cnt;
  reg  [7:0]  conv_cnt;
  wire        go = cmd_valid && cmd_code != 2'h0 && !cal_busy;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // counts clear outside calibration so each run is measured alone
  always @(posedge clk_sys) begin
    busy_cnt <= (rst || !cal_busy) ? 16'h0000 : busy_cnt + 16'h0001;
    conv_cnt <= (rst || !cal_busy) ? 8'h00 : conv_cnt + {7'h00, filt_valid};
  end
  a_result_answer: assert property (
    filt_valid && !cal_busy && !cmd_valid && !power_down
    |=> out_valid && !conversion_done_flag_n) else $error("no result");
  a_flag_pulse: assert property (
    $fell(conversion_done_flag_n) |=> conversion_done_flag_n)
    else $error("flag low too long");
  a_quiet_in_cal: assert property (
    cal_busy && $past(cal_busy) |-> !out_valid) else $error("result in cal");
  a_cal_start: assert property (
    go |=> cal_busy && filter_restart ##1 !filter_restart)
    else $error("cal start");
  a_int_zero: assert property (
    go && cmd_code == 2'h2 |=> input_disconnect && internal_zero_apply)
    else $error("inputs not isolated");
  a_cal_length: assert property (
    $fell(cal_busy) |-> busy_cnt >= 16'd50 && conv_cnt >= 8'd16)
    else $error("cal too short");
  a_cal_done: assert property (
    $fell(cal_busy) |-> !conversion_done_flag_n) else $error("no done");
  a_pd_defer: assert property (
    $rose(power_down) |-> !cal_busy) else $error("early power down");
  c_cal_end: cover property ($fell(cal_busy));
  c_int_cal: cover property (go && cmd_code == 2'h2);
  c_pd: cover property ($rose(power_down));
endmodule
bind acs_scaler acs_scaler_chk u_chk (.clk_sys(clk_sys), .rst(rst),
  .filt_valid(filt_valid), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .out_valid(out_valid), .conversion_done_flag_n(conversion_done_flag_n),
  .cal_busy(cal_busy), .filter_restart(filter_restart),
  .input_disconnect(input_disconnect), .power_down(power_down),
  .internal_zero_apply(internal_zero_apply));

// ---- sim/acs_src_model.sv ----
// filter source model: modulator ticks and one result every 20 clocks
// assumes the bench sets din to the level the host applies at the inputs
`timescale 1ns/100ps
module acs_src_model (
  input  wire        clk_sys,
  input  wire [15:0] din,
  input  wire        zero_int,
  output reg  [15:0] filt_data = 16'h0000,
  output reg         filt_valid = 1'b0,
  output reg         mod_tick = 1'b0
);
  integer n = 0;
  always @(negedge clk_sys) begin
    n <= n + 1;
    mod_tick <= (n % 4) == 0;
    filt_valid <= (n % 20) == 5;
    if ((n % 20) == 5)
      filt_data <= zero_int ? 16'h0003 : din;
    else
      filt_data <= ~filt_data;
  end
endmodule

// ---- sim/tb.sv ----
// self-checking bench for acs_scaler with the filter source model
// assumes acs_defines.vh on the include path
`timescale 1ns/100ps
`include "acs_defines.vh"
`define TB_CHK(n,e,s) begin compares = compares + 1; \
  if ((e) !== (s)) begin error_cnt = error_cnt + 1; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
  reg         clk_sys = 0, rst = 1, cmd_valid = 0, reg_wr = 0;
  reg         power_down_req = 0, chk_en = 0, start_low = 0;
  reg  [1:0]  cmd_code = 0;
  reg  [2:0]  reg_addr = 0;
  reg  [7:0]  reg_wdata = 0;
  reg  [15:0] din = 0, prev_in = 0;
  reg  [23:0] ofs_m = `ACS_OFS_RESET, gain_m = `ACS_GAIN_RESET;
  reg  [31:0] r;
  integer     error_cnt = 0, compares = 0, seed = 32'h8266, i;
  wire [15:0] filt_data, out_code;
  wire [7:0]  reg_rdata;
  wire        filt_valid, mod_tick, out_valid, done_n, busy, pd;
  wire        disc, zero_ap, restart;
  acs_src_model src (.clk_sys(clk_sys), .din(din), .zero_int(disc),
    .filt_data(filt_data), .filt_valid(filt_valid), .mod_tick(mod_tick));
  acs_scaler dut (.clk_sys(clk_sys), .rst(rst), .filt_data(filt_data),
    .filt_valid(filt_valid), .mod_tick(mod_tick), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .power_down_req(power_down_req),
    .start_pin_low(start_low), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .out_code(out_code),
    .conversion_done_flag_n(done_n), .out_valid(out_valid),
    .input_disconnect(disc), .internal_zero_apply(zero_ap),
    .filter_restart(restart), .cal_busy(busy), .power_down(pd));
  always #10 clk_sys = ~clk_sys;
  function [15:0] f_exp(input [15:0] x);
    reg signed [63:0] p;
    begin
      p = ($signed({{48{x[15]}}, x}) -
           $signed({{48{ofs_m[23]}}, ofs_m[23:8]})) *
          $signed({40'h0, gain_m});
      p = p >>> `ACS_GAIN_SHIFT;
      f_exp = p > 64'sh7FFF ? 16'h7FFF : p < -64'sh8000 ? 16'h8000 : p[15:0];
    end
  endfunction
  always @(posedge clk_sys) begin
    if (out_valid && chk_en)
      `TB_CHK("out_code", f_exp(prev_in), out_code)
    if (filt_valid)
      prev_in <= filt_data;
  end
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 0;
    end
  endtask
  task rd24(input [2:0] a, input [23:0] e);
    integer k;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        @(negedge clk_sys);
        reg_addr = a + k[2:0];
        @(negedge clk_sys);
        @(negedge clk_sys);
        `TB_CHK("reg_rdata", e[8*k+:8], reg_rdata)
      end
    end
  endtask
  task setcal(input [23:0] o, input [23:0] g);
    integer k;
    begin
      chk_en = 0;
      for (k = 0; k < 3; k = k + 1) begin
        wr(k[2:0], o[8*k+:8]);
        wr(k[2:0] + 3'h3, g[8*k+:8]);
      end
      ofs_m = o;
      gain_m = g;
      repeat (2) @(negedge clk_sys);
      chk_en = 1;
    end
  endtask
  // a write during gain calibration must be dropped; power-down waits
  task cal(input [1:0] c, input [15:0] lvl, input [23:0] e);
    integer k;
    begin
      chk_en = 0;
      din = lvl;
      @(negedge clk_sys);
      cmd_valid = 1;
      cmd_code = c;
      @(negedge clk_sys);
      cmd_valid = 0;
      if (c == `ACS_CMD_INT_OFS)
        start_low = 1;
      if (c == `ACS_CMD_SYS_GAIN) begin
        power_down_req = 1;
        wr(`ACS_REG_OFS0, 8'hAA);
      end
      // host stays quiet until calibration ends
      for (k = 0; k < 2000 && busy !== 1'b0; k = k + 1)
        @(negedge clk_sys);
      `TB_CHK("cal_busy", 1'b0, busy)
      if (c == `ACS_CMD_INT_OFS) begin
        `TB_CHK("power_down", 1'b1, pd)
        start_low = 0;
      end
      if (c == `ACS_CMD_SYS_GAIN) begin
        rd24(`ACS_REG_GAIN0, e);
        gain_m = e;
      end else begin
        rd24(`ACS_REG_OFS0, e);
        ofs_m = e;
      end
      chk_en = 1;
      repeat (45) @(negedge clk_sys);
    end
  endtask
  task give_verdict;
    begin
      if (error_cnt == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 0;
    rd24(`ACS_REG_OFS0, `ACS_OFS_RESET);
    rd24(`ACS_REG_GAIN0, `ACS_GAIN_RESET);
    rd24(3'h6, 24'h000000);
    chk_en = 1;
    for (i = 0; i < 14; i = i + 1) begin
      r = $random(seed);
      din = i < 4 ? 16'h0000 : r[15:0];
      setcal(i == 0 ? 24'h000100 : i == 1 ? 24'hFFFF00 :
             i == 2 ? 24'h7FFFFF : i == 3 ? 24'h800000 : r[31:8],
             i < 4 ? 24'h400000 : {r[7:0], r[23:8]});
      repeat (45) @(negedge clk_sys);
    end
    cal(`ACS_CMD_SYS_OFS, 16'h0012, 24'h001200);
    cal(`ACS_CMD_INT_OFS, 16'h1234, 24'h000300);
    setcal(24'h000000, 24'h400000);
    cal(`ACS_CMD_SYS_GAIN, 16'h4000, 24'h7FFF00);
    `TB_CHK("power_down", 1'b1, pd)
    rd24(`ACS_REG_OFS0, 24'h000000);
    give_verdict;
  end
  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
endmodule
